// file: rtl/rx_pkg.sv
/*
  Constants shared by the serial receiver: register offsets on the
  Avalon-MM slave, bit positions, sampling figures and the state type.
  Assumes a 32-bit data bus with byte addresses; each register sits in
  the low byte of its own aligned word.
*/
package rx_pkg;
  // Byte offsets of the registers
  localparam logic [5:0] OFS_GIC   = 6'h00;
  localparam logic [5:0] OFS_FLAGS = 6'h04;
  localparam logic [5:0] OFS_ENAB  = 6'h08;
  localparam logic [5:0] OFS_PRIO  = 6'h0c;
  localparam logic [5:0] OFS_RSC   = 6'h10;
  localparam logic [5:0] OFS_RXBUF = 6'h14;
  localparam logic [5:0] OFS_TSC   = 6'h18;
  localparam logic [5:0] OFS_BAUD  = 6'h1c;
  localparam logic [5:0] OFS_DIVH  = 6'h20;
  localparam logic [5:0] OFS_DIVL  = 6'h24;

  // Field positions
  localparam int GIE_POS   = 7;
  localparam int PERIPHERAL_INTERRUPT_ENABLE_POS  = 6;
  localparam int RCV_POS   = 5;
  localparam int SERIAL_PORT_ENABLE_POS  = 7;
  localparam int RX9_POS   = 6;
  localparam int CONTINUOUS_RECEIVE_ENABLE_POS  = 4;
  localparam int ADDRESS_DETECT_ENABLE_POS = 3;
  localparam int FRAMING_ERROR_FLAG_POS  = 2;
  localparam int OVERRUN_ERROR_FLAG_POS  = 1;
  localparam int RECEIVED_NINTH_BIT_POS  = 0;
  localparam int SYNC_POS  = 4;
  localparam int HIGH_SPEED_RATE_SELECT_POS  = 2;
  localparam int RCIDL_POS = 6;
  localparam int WIDE_DIVIDER_SELECT_POS = 3;
  localparam int WUE_POS   = 1;

  // Reset value of every control byte
  localparam logic [7:0] RESET_BYTE = 8'h00;

  // Sampling: ticks at sixteen per bit, decision on the middle sample
  localparam logic [3:0] SAMPLE_MID  = 4'h8;
  localparam logic [3:0] SAMPLE_LAST = 4'hf;
  localparam logic [3:0] LAST_BIT_8  = 4'h7;
  localparam logic [3:0] LAST_BIT_9  = 4'h8;

  // Generator step in quarter clocks per clock for each rate range
  localparam logic [4:0] STEP_X64  = 5'h01;
  localparam logic [4:0] STEP_X16  = 5'h04;
  localparam logic [4:0] STEP_FAST = 5'h10;

  localparam logic [1:0] BUF_DEPTH = 2'h2;

  typedef enum logic [1:0] {ST_IDLE, ST_START, ST_DATA, ST_STOP} rx_state_e;
endpackage

// file: rtl/baud_if.sv
/*
  Carrier between the receiver and its rate generator.
  Assumes both ends share one clock.
*/
interface baud_if;
  logic [15:0] divisor;
  logic        high_speed_rate_select;
  logic        wide_divider_select;
  logic        run;
  logic        tick;

  modport gen  (input divisor, high_speed_rate_select, wide_divider_select, run,
                output tick);
  modport user (output divisor, high_speed_rate_select, wide_divider_select, run,
                input tick);
endinterface

// file: rtl/baud_tick_gen.sv
/*
  Rate generator: one tick per sixteenth of a bit.
  Assumes the divisor and selects stay stable while it runs.
*/
module baud_tick_gen (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic sys_rst_i,
  input  wire logic ce_i,
  // Control and tick
  baud_if.gen       bif
);
  logic [18:0] acc_q;
  logic [18:0] acc_d;
  logic        tick_q;
  logic        tick_d;
  logic [18:0] lim;
  logic [18:0] sum;
  logic [4:0]  step;

  // Phase accumulator in quarter clocks, so the fastest range still
  // averages the right rate when the period is not a whole clock count
  always_comb begin
    lim = bif.wide_divider_select
        ? {1'b0, bif.divisor, 2'h0} + 19'h00004
        : {9'h000, bif.divisor[7:0], 2'h0} + 19'h00004;
    case ({bif.wide_divider_select, bif.high_speed_rate_select})
      2'h0:    step = rx_pkg::STEP_X64;
      2'h3:    step = rx_pkg::STEP_FAST;
      default: step = rx_pkg::STEP_X16;
    endcase
    sum    = acc_q + {14'h0000, step};
    acc_d  = sum;
    tick_d = 1'b0;
    if (!bif.run) begin
      acc_d = '0;
    end else if (sum >= lim) begin
      tick_d = 1'b1;
      // At most one tick per clock; excess phase is dropped
      acc_d  = (sum - lim >= lim) ? '0 : sum - lim;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      acc_q  <= '0;
      tick_q <= 1'b0;
    end else if (ce_i) begin
      acc_q  <= acc_d;
      tick_q <= tick_d;
    end
  end

  assign bif.tick = tick_q & ce_i;
endmodule

// file: rtl/async_serial_receiver_wake.sv
/*
  Asynchronous serial receiver with address detect and wake on edge,
  behind an Avalon-MM slave with waitrequest.
  Assumes the receive line and sleep_i are synchronous to clk_i and
  that the block clock keeps running while the CPU sleeps.
*/
// The implementer's own choices: the address map and the Avalon-MM slave port.
// Functional notes
// - Sixteen-times sampling recovers bits for shifter
// - Bit rate from sixteen-bit divisor pair
// - Async only with clocked mode off, enabled
// - Nine data bits when ninth enable set
// - Frames accepted only while continuous receive set
// - Frame done sets flag, interrupt if enabled
// - Status shows ninth bit and errors
// - Data read returns oldest frame low byte
// - Clearing continuous receive clears the overrun error
// - Address detect with nine bits; off passes all
// - Receive interrupt priority selectable by bit
// - Sleep stops rate generator and reception
// - Wake enable idles receiver, watches line
// - Falling line edge is the wake event
// - Wake event sets the receive flag
// - Reading data register clears wake condition
// - Rising edge after wake clears wake enable
// - Frame is start, eight/nine data, stop
// - Data bits assembled least significant first
// - Bit period 64, 16 or 4 clocks per divisor plus one
module async_serial_receiver_wake (
  // Clock, reset, enable
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        ce_i,
  // CPU mode and serial line
  input  wire logic        sleep_i,
  input  wire logic        receive_line_i,
  // Avalon-MM slave
  input  wire logic [5:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  // Interrupt request
  output logic             rx_irq_o,
  output logic             rx_irq_high_o
);
  // Bus and configuration state
  logic        waitreq_q, waitreq_d;
  logic [31:0] rdata_q, rdata_d;
  logic        gie_q, gie_d, peripheral_interrupt_enable_q, peripheral_interrupt_enable_d;
  logic        receive_interrupt_enable_q, receive_interrupt_enable_d, receive_interrupt_priority_q, receive_interrupt_priority_d;
  logic        serial_port_enable_q, serial_port_enable_d, rx9_q, rx9_d;
  logic        continuous_receive_enable_q, continuous_receive_enable_d, address_detect_enable_q, address_detect_enable_d;
  logic        sync_q, sync_d, high_speed_rate_select_q, high_speed_rate_select_d, wide_divider_select_q, wide_divider_select_d;
  logic [7:0]  divh_q, divh_d, divl_q, divl_d;
  logic        irq_q, irq_d;
  logic [7:0]  rd_byte;
  logic        wr_fire, rd_fire, rd_rx, wr_baud;

  // Receiver state
  rx_pkg::rx_state_e state_q, state_d;
  logic [3:0]  scnt_q, scnt_d;
  logic [3:0]  bitn_q, bitn_d;
  logic [8:0]  shift_q, shift_d;
  logic [1:0]  samp_q, samp_d;
  logic        done_q, done_d;
  logic [8:0]  frame_q, frame_d;
  logic        framing_error_flag_q, framing_error_flag_d;
  logic        bit_val, rx_en;

  // Buffer, error and wake state
  logic [9:0]  ent_q [2];
  logic [9:0]  ent_d [2];
  logic [1:0]  fill_q, fill_d;
  logic        overrun_error_flag_q, overrun_error_flag_d;
  logic        wue_q, wue_d;
  logic        wake_seen_q, wake_seen_d;
  logic        wake_flag_q, wake_flag_d;
  logic        line_q;
  logic        fall, rise, pop, keep, addr_mode, rcv_flag;
  logic [1:0]  base;

  baud_if bif ();

  baud_tick_gen u_gen (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .ce_i      (ce_i),
    .bif       (bif.gen)
  );

  assign bif.divisor                = {divh_q, divl_q};
  assign bif.high_speed_rate_select = high_speed_rate_select_q;
  assign bif.wide_divider_select    = wide_divider_select_q;
  // Sleep halts the generator outright
  assign bif.run                    = serial_port_enable_q & ~sync_q & ~sleep_i;

  assign wr_fire = avs_write_i & ~waitreq_q & avs_byteenable_i[0];
  assign rd_fire = avs_read_i & ~waitreq_q;
  assign rd_rx   = rd_fire & (avs_address_i == rx_pkg::OFS_RXBUF);
  assign wr_baud = wr_fire & (avs_address_i == rx_pkg::OFS_BAUD);

  assign addr_mode = rx9_q & address_detect_enable_q;
  assign rcv_flag  = (fill_q != 2'h0) | wake_flag_q;
  assign fall      = line_q & ~receive_line_i;
  assign rise      = ~line_q & receive_line_i;
  assign rx_en     = serial_port_enable_q & ~sync_q & continuous_receive_enable_q & ~wue_q & ~sleep_i & ~overrun_error_flag_q;

  // Register read view
  always_comb begin
    rd_byte = rx_pkg::RESET_BYTE;
    case (avs_address_i)
      rx_pkg::OFS_GIC: begin
        rd_byte[rx_pkg::GIE_POS]  = gie_q;
        rd_byte[rx_pkg::PERIPHERAL_INTERRUPT_ENABLE_POS] = peripheral_interrupt_enable_q;
      end
      rx_pkg::OFS_FLAGS: rd_byte[rx_pkg::RCV_POS] = rcv_flag;
      rx_pkg::OFS_ENAB:  rd_byte[rx_pkg::RCV_POS] = receive_interrupt_enable_q;
      rx_pkg::OFS_PRIO:  rd_byte[rx_pkg::RCV_POS] = receive_interrupt_priority_q;
      rx_pkg::OFS_RSC: begin
        rd_byte[rx_pkg::SERIAL_PORT_ENABLE_POS]  = serial_port_enable_q;
        rd_byte[rx_pkg::RX9_POS]   = rx9_q;
        rd_byte[rx_pkg::CONTINUOUS_RECEIVE_ENABLE_POS]  = continuous_receive_enable_q;
        rd_byte[rx_pkg::ADDRESS_DETECT_ENABLE_POS] = address_detect_enable_q;
        rd_byte[rx_pkg::FRAMING_ERROR_FLAG_POS]  = ent_q[0][9];
        rd_byte[rx_pkg::OVERRUN_ERROR_FLAG_POS]  = overrun_error_flag_q;
        rd_byte[rx_pkg::RECEIVED_NINTH_BIT_POS]  = ent_q[0][8];
      end
      rx_pkg::OFS_RXBUF: rd_byte = ent_q[0][7:0];
      rx_pkg::OFS_TSC: begin
        rd_byte[rx_pkg::SYNC_POS] = sync_q;
        rd_byte[rx_pkg::HIGH_SPEED_RATE_SELECT_POS] = high_speed_rate_select_q;
      end
      rx_pkg::OFS_BAUD: begin
        rd_byte[rx_pkg::RCIDL_POS] = (state_q == rx_pkg::ST_IDLE);
        rd_byte[rx_pkg::WIDE_DIVIDER_SELECT_POS] = wide_divider_select_q;
        rd_byte[rx_pkg::WUE_POS]   = wue_q;
      end
      rx_pkg::OFS_DIVH: rd_byte = divh_q;
      rx_pkg::OFS_DIVL: rd_byte = divl_q;
      default: rd_byte = rx_pkg::RESET_BYTE;
    endcase
  end

  // Bus handshake and configuration registers
  always_comb begin
    waitreq_d = 1'b1;
    rdata_d   = rdata_q;
    if ((avs_read_i | avs_write_i) & waitreq_q) begin
      waitreq_d = 1'b0;
      rdata_d   = {24'h000000, rd_byte};
    end
    {gie_d, peripheral_interrupt_enable_d, receive_interrupt_enable_d, receive_interrupt_priority_d} = {gie_q, peripheral_interrupt_enable_q, receive_interrupt_enable_q, receive_interrupt_priority_q};
    {serial_port_enable_d, rx9_d, continuous_receive_enable_d, address_detect_enable_d} = {serial_port_enable_q, rx9_q, continuous_receive_enable_q, address_detect_enable_q};
    {sync_d, high_speed_rate_select_d, wide_divider_select_d} = {sync_q, high_speed_rate_select_q, wide_divider_select_q};
    divh_d = divh_q;
    divl_d = divl_q;
    if (wr_fire) begin
      case (avs_address_i)
        rx_pkg::OFS_GIC: begin
          gie_d  = avs_writedata_i[rx_pkg::GIE_POS];
          peripheral_interrupt_enable_d = avs_writedata_i[rx_pkg::PERIPHERAL_INTERRUPT_ENABLE_POS];
        end
        rx_pkg::OFS_ENAB: receive_interrupt_enable_d = avs_writedata_i[rx_pkg::RCV_POS];
        rx_pkg::OFS_PRIO: receive_interrupt_priority_d = avs_writedata_i[rx_pkg::RCV_POS];
        rx_pkg::OFS_RSC: begin
          serial_port_enable_d  = avs_writedata_i[rx_pkg::SERIAL_PORT_ENABLE_POS];
          rx9_d   = avs_writedata_i[rx_pkg::RX9_POS];
          continuous_receive_enable_d  = avs_writedata_i[rx_pkg::CONTINUOUS_RECEIVE_ENABLE_POS];
          address_detect_enable_d = avs_writedata_i[rx_pkg::ADDRESS_DETECT_ENABLE_POS];
        end
        rx_pkg::OFS_TSC: begin
          sync_d = avs_writedata_i[rx_pkg::SYNC_POS];
          high_speed_rate_select_d = avs_writedata_i[rx_pkg::HIGH_SPEED_RATE_SELECT_POS];
        end
        rx_pkg::OFS_BAUD: wide_divider_select_d = avs_writedata_i[rx_pkg::WIDE_DIVIDER_SELECT_POS];
        rx_pkg::OFS_DIVH: divh_d = avs_writedata_i[7:0];
        rx_pkg::OFS_DIVL: divl_d = avs_writedata_i[7:0];
        default: divl_d = divl_q;
      endcase
    end
    // Global enables gate the request; priority goes out beside it
    irq_d = rcv_flag & receive_interrupt_enable_q & gie_q & peripheral_interrupt_enable_q;
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      waitreq_q <= 1'b1;
      rdata_q   <= '0;
      {gie_q, peripheral_interrupt_enable_q, receive_interrupt_enable_q, receive_interrupt_priority_q} <= '0;
      {serial_port_enable_q, rx9_q, continuous_receive_enable_q, address_detect_enable_q} <= '0;
      {sync_q, high_speed_rate_select_q, wide_divider_select_q} <= '0;
      divh_q    <= rx_pkg::RESET_BYTE;
      divl_q    <= rx_pkg::RESET_BYTE;
      irq_q     <= 1'b0;
    end else if (ce_i) begin
      waitreq_q <= waitreq_d;
      rdata_q   <= rdata_d;
      {gie_q, peripheral_interrupt_enable_q, receive_interrupt_enable_q, receive_interrupt_priority_q} <= {gie_d, peripheral_interrupt_enable_d, receive_interrupt_enable_d, receive_interrupt_priority_d};
      {serial_port_enable_q, rx9_q, continuous_receive_enable_q, address_detect_enable_q} <= {serial_port_enable_d, rx9_d, continuous_receive_enable_d, address_detect_enable_d};
      {sync_q, high_speed_rate_select_q, wide_divider_select_q} <= {sync_d, high_speed_rate_select_d, wide_divider_select_d};
      divh_q    <= divh_d;
      divl_q    <= divl_d;
      irq_q     <= irq_d;
    end
  end

  // Three-sample majority around mid-bit rejects a single glitch
  assign bit_val = (samp_q[1] & samp_q[0]) | (samp_q[1] & receive_line_i)
                 | (samp_q[0] & receive_line_i);

  // Frame receiver
  always_comb begin
    state_d = state_q;
    scnt_d  = scnt_q;
    bitn_d  = bitn_q;
    shift_d = shift_q;
    samp_d  = samp_q;
    frame_d = frame_q;
    framing_error_flag_d  = framing_error_flag_q;
    done_d  = 1'b0;
    if (!rx_en) begin
      state_d = rx_pkg::ST_IDLE;
    end else if (bif.tick) begin
      samp_d = {samp_q[0], receive_line_i};
      scnt_d = scnt_q + 4'h1;
      case (state_q)
        rx_pkg::ST_IDLE: begin
          scnt_d = '0;
          if (!receive_line_i) begin
            state_d = rx_pkg::ST_START;
          end
        end
        rx_pkg::ST_START: begin
          if (scnt_q == rx_pkg::SAMPLE_MID && bit_val) begin
            state_d = rx_pkg::ST_IDLE;
          end else if (scnt_q == rx_pkg::SAMPLE_LAST) begin
            state_d = rx_pkg::ST_DATA;
            bitn_d  = '0;
          end
        end
        rx_pkg::ST_DATA: begin
          if (scnt_q == rx_pkg::SAMPLE_MID) begin
            shift_d = {bit_val, shift_q[8:1]};
          end
          if (scnt_q == rx_pkg::SAMPLE_LAST) begin
            if (bitn_q == (rx9_q ? rx_pkg::LAST_BIT_9 : rx_pkg::LAST_BIT_8)) begin
              state_d = rx_pkg::ST_STOP;
            end else begin
              bitn_d = bitn_q + 4'h1;
            end
          end
        end
        rx_pkg::ST_STOP: begin
          if (scnt_q == rx_pkg::SAMPLE_MID) begin
            // Back to idle at mid-stop so a following start is not missed
            state_d = rx_pkg::ST_IDLE;
            done_d  = 1'b1;
            framing_error_flag_d  = ~bit_val;
            frame_d = rx9_q ? shift_q : {1'b0, shift_q[8:1]};
          end
        end
        default: state_d = rx_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state_q <= rx_pkg::ST_IDLE;
      scnt_q  <= '0;
      bitn_q  <= '0;
      shift_q <= '0;
      samp_q  <= '0;
      done_q  <= 1'b0;
      frame_q <= '0;
      framing_error_flag_q  <= 1'b0;
    end else if (ce_i) begin
      state_q <= state_d;
      scnt_q  <= scnt_d;
      bitn_q  <= bitn_d;
      shift_q <= shift_d;
      samp_q  <= samp_d;
      done_q  <= done_d;
      frame_q <= frame_d;
      framing_error_flag_q  <= framing_error_flag_d;
    end
  end

  // Two-entry buffer, overrun and wake
  always_comb begin
    pop  = rd_rx & (fill_q != 2'h0);
    base = fill_q - {1'b0, pop};
    keep = done_q & ~(addr_mode & ~frame_q[8]);
    ent_d[0] = pop ? ent_q[1] : ent_q[0];
    ent_d[1] = ent_q[1];
    fill_d   = base;
    overrun_error_flag_d   = overrun_error_flag_q;
    if (keep) begin
      if (base == rx_pkg::BUF_DEPTH) begin
        overrun_error_flag_d = 1'b1;
      end else begin
        ent_d[base[0]] = {framing_error_flag_q, frame_q};
        fill_d = base + 2'h1;
      end
    end
    if (!continuous_receive_enable_q) begin
      overrun_error_flag_d = 1'b0;
    end
    wake_seen_d = wake_seen_q;
    wue_d       = wue_q;
    if (wue_q & fall) begin
      wake_seen_d = 1'b1;
    end else if (wake_seen_q & rise) begin
      wake_seen_d = 1'b0;
      wue_d       = 1'b0;
    end
    if (wr_baud) begin
      wue_d = avs_writedata_i[rx_pkg::WUE_POS];
    end
    if (!wue_d) begin
      wake_seen_d = 1'b0;
    end
    wake_flag_d = wake_flag_q & ~rd_rx;
    if (wue_q & fall) begin
      wake_flag_d = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      ent_q[0]    <= '0;
      ent_q[1]    <= '0;
      fill_q      <= '0;
      overrun_error_flag_q      <= 1'b0;
      wue_q       <= 1'b0;
      wake_seen_q <= 1'b0;
      wake_flag_q <= 1'b0;
      line_q      <= 1'b1;
    end else if (ce_i) begin
      ent_q       <= ent_d;
      fill_q      <= fill_d;
      overrun_error_flag_q      <= overrun_error_flag_d;
      wue_q       <= wue_d;
      wake_seen_q <= wake_seen_d;
      wake_flag_q <= wake_flag_d;
      line_q      <= receive_line_i;
    end
  end

  assign avs_readdata_o    = rdata_q;
  assign avs_waitrequest_o = waitreq_q;
  assign rx_irq_o          = irq_q;
  assign rx_irq_high_o     = receive_interrupt_priority_q;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  frame_end_stop_a: assert property (
    done_q |-> $past(state_q) == rx_pkg::ST_STOP)
    else $error("frame completed outside the stop bit");

  irq_follow_a: assert property (
    ce_i && rcv_flag && receive_interrupt_enable_q && gie_q && peripheral_interrupt_enable_q |=> rx_irq_o)
    else $error("receive request missing with flag and enables set");

  addr_drop_a: assert property (
    ce_i && done_q && addr_mode && !frame_q[8] && !rd_rx |=> fill_q == $past(fill_q))
    else $error("address mode stored a frame with ninth bit low");

  overrun_set_a: assert property (
    ce_i && keep && continuous_receive_enable_q && fill_q == rx_pkg::BUF_DEPTH && !rd_rx |=> overrun_error_flag_q)
    else $error("full buffer did not flag overrun");

  continuous_receive_enable_clear_a: assert property (
    ce_i && !continuous_receive_enable_q |=> !overrun_error_flag_q)
    else $error("overrun survived a cleared receive enable");

  wake_idle_a: assert property (
    ce_i && wue_q |=> state_q == rx_pkg::ST_IDLE)
    else $error("receiver active while wake enable set");

  wake_event_a: assert property (
    ce_i && wue_q && fall |=> wake_flag_q && rcv_flag)
    else $error("falling edge in wake mode did not raise the flag");

  wake_exit_a: assert property (
    ce_i && wake_seen_q && rise && !wr_baud |=> !wue_q)
    else $error("wake enable not cleared on rising edge");

  wake_read_a: assert property (
    ce_i && rd_rx && !(wue_q && fall) |=> !wake_flag_q)
    else $error("data read did not clear the wake condition");

  bus_answer_a: assert property (
    ce_i && (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("slave failed to answer one edge after the request");
endmodule

// file: verif/serial_tx_model.sv
/*
  Behavioural far-end transmitter driving the receive line.
  Assumes the caller starts each task just after a rising clock edge.
*/
module serial_tx_model (
  // Clock
  input  wire logic clk_i,
  // Serial line, idle high
  output logic      line_o
);
  timeunit 1ns;
  timeprecision 1ps;

  initial line_o = 1'b1;

  task automatic hold(input logic v, input int n);
    line_o <= v;
    repeat (n) @(posedge clk_i);
  endtask

  // A bad stop stays low only past the middle sample, so no false start follows
  task automatic send(input logic [8:0] d, input int nb, input logic stop_ok, input int bc);
    hold(1'b0, bc);
    for (int i = 0; i < nb; i++) hold(d[i], bc);
    if (stop_ok) hold(1'b1, bc);
    else begin
      hold(1'b0, bc * 9 / 16);
      hold(1'b1, bc - bc * 9 / 16);
    end
  endtask

  // Zero character, then an idle gap long enough for the receiver to settle
  task automatic wake_zero(input int bc);
    hold(1'b0, bc * 9);
    hold(1'b1, bc * 4);
  endtask
endmodule

// file: verif/async_serial_receiver_wake_tb_top.sv
/*
  Self-checking bench: register bus master, expectation queue and monitor.
  Assumes the serial model above and a running clock during sleep.
*/
module async_serial_receiver_wake_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {logic [31:0] val; logic [31:0] msk;} note_s;

  logic        clk_i = 1'b0;
  logic        sys_rst_i, ce_i, sleep_i, rx_line;
  logic [5:0]  avs_address_i;
  logic        avs_read_i, avs_write_i;
  logic [31:0] avs_writedata_i, avs_readdata_o;
  logic [3:0]  avs_byteenable_i;
  logic        avs_waitrequest_o, rx_irq_o, rx_irq_high_o;
  int          mismatches = 0;
  int          comparisons = 0;
  note_s       notes[$];
  note_s       cur;
  logic [8:0]  d9;
  logic [7:0]  ov [4];
  int          bc = 64;
  logic [7:0]  rate_cfg [6][4] = '{'{8'h00, 8'h00, 8'h00, 8'h00}, '{8'h04, 8'h00, 8'h00, 8'h03},
    '{8'h00, 8'h08, 8'h00, 8'h03}, '{8'h04, 8'h08, 8'h00, 8'h0f}, '{8'h04, 8'h08, 8'h01, 8'h00},
    '{8'h04, 8'h00, 8'hff, 8'h03}};
  int          rate_bc [6] = '{64, 64, 64, 64, 1028, 64};

  always #2.5 clk_i = ~clk_i;

  serial_tx_model u_serial_tx_model (.clk_i(clk_i), .line_o(rx_line));

  async_serial_receiver_wake u_async_serial_receiver_wake (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i), .sleep_i(sleep_i),
    .receive_line_i(rx_line), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .rx_irq_o(rx_irq_o), .rx_irq_high_o(rx_irq_high_o));

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] msk);
    comparisons++;
    if (((got ^ exp) & msk) !== 32'h0) begin
      mismatches++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Answers are checked where they stand, at the edge that samples waitrequest low
  always @(posedge clk_i) begin
    if (avs_read_i && avs_waitrequest_o === 1'b0) begin
      if (notes.size() == 0) begin
        mismatches++;
        $display("ERROR at %0t: read answer with no expectation", $time);
      end else begin
        cur = notes.pop_front();
        cmp(avs_readdata_o, cur.val, cur.msk);
      end
    end
  end

  task automatic bus(input logic wr, input logic [5:0] a, input logic [7:0] d);
    int n;
    n = 0;
    avs_address_i   <= a;
    avs_writedata_i <= {24'h0, d};
    avs_write_i     <= wr;
    avs_read_i      <= ~wr;
    @(posedge clk_i);
    while (avs_waitrequest_o !== 1'b0) begin
      n++;
      if (n > 50) begin
        mismatches++;
        $display("ERROR at %0t: bus answer timed out", $time);
        complete_run();
      end
      @(posedge clk_i);
    end
    avs_write_i <= 1'b0;
    avs_read_i  <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic rd(input logic [5:0] a, input logic [7:0] e, input logic [7:0] m);
    notes.push_back('{{24'h0, e}, {24'hffffff, m}});
    bus(1'b0, a, 8'h00);
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask

  // One frame under a given control byte; sta of zero means the frame must be dropped
  task automatic one(input logic [7:0] rsc, input logic [8:0] d, input logic ok,
                     input logic [7:0] sta);
    wr(rx_pkg::OFS_RSC, rsc);
    u_serial_tx_model.send(d, rsc[6] ? 9 : 8, ok, bc);
    if (sta == 8'h00) rd(rx_pkg::OFS_FLAGS, 8'h00, 8'hff);
    else begin
      rd(rx_pkg::OFS_FLAGS, 8'h20, 8'hff);
      cmp({31'h0, rx_irq_o}, 32'h1, 32'h1);
      rd(rx_pkg::OFS_RSC, sta, 8'hff);
      rd(rx_pkg::OFS_RXBUF, d[7:0], 8'hff);
      rd(rx_pkg::OFS_FLAGS, 8'h00, 8'hff);
      cmp({31'h0, rx_irq_o}, 32'h0, 32'h1);
    end
  endtask

  initial begin
    sys_rst_i = 1'b1;
    ce_i = 1'b1;
    sleep_i = 1'b0;
    avs_address_i = 6'h00;
    avs_read_i = 1'b0;
    avs_write_i = 1'b0;
    avs_writedata_i = 32'h0;
    avs_byteenable_i = 4'hf;
    void'($urandom(32'hdc05d1fa));
    repeat (12) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    @(posedge clk_i);
    // Ten registers and one unmapped word; the idle status bit is left unchecked
    for (int i = 0; i < 11; i++) rd(6'(i * 4), 8'h00, (i == 7) ? 8'hbf : 8'hff);
    $display("test reset_values done");
    // A write without the low byte lane must leave the register alone
    avs_byteenable_i <= 4'he;
    wr(rx_pkg::OFS_DIVL, 8'h5a);
    avs_byteenable_i <= 4'hf;
    rd(rx_pkg::OFS_DIVL, 8'h00, 8'hff);
    // With the clock enable low the slave must not answer
    ce_i <= 1'b0;
    fork
      wr(rx_pkg::OFS_DIVH, 8'h11);
      begin
        repeat (10) @(posedge clk_i);
        cmp({31'h0, avs_waitrequest_o}, 32'h1, 32'h1);
        ce_i <= 1'b1;
      end
    join
    rd(rx_pkg::OFS_DIVH, 8'h11, 8'hff);
    $display("test lanes_enable done");
    wr(rx_pkg::OFS_ENAB, 8'h20);
    wr(rx_pkg::OFS_GIC, 8'hc0);
    wr(rx_pkg::OFS_PRIO, 8'h20);
    repeat (2) @(posedge clk_i);
    cmp({31'h0, rx_irq_high_o}, 32'h1, 32'h1);
    for (int k = 0; k < 6; k++) begin
      wr(rx_pkg::OFS_TSC, rate_cfg[k][0]);
      wr(rx_pkg::OFS_BAUD, rate_cfg[k][1]);
      wr(rx_pkg::OFS_DIVH, rate_cfg[k][2]);
      wr(rx_pkg::OFS_DIVL, rate_cfg[k][3]);
      bc = rate_bc[k];
      d9 = 9'($urandom_range(0, 255));
      one(8'h90, d9, 1'b1, 8'h90);
    end
    $display("test rates done");
    d9 = 9'($urandom_range(0, 255));
    one(8'hd0, {1'b1, d9[7:0]}, 1'b1, 8'hd1);
    one(8'hd0, {1'b0, d9[7:0]}, 1'b1, 8'hd0);
    one(8'hd8, {1'b0, d9[7:0]}, 1'b1, 8'h00);
    one(8'hd8, {1'b1, d9[7:0]}, 1'b1, 8'hd9);
    one(8'hd0, {1'b0, d9[7:0]}, 1'b1, 8'hd0);
    one(8'h90, d9, 1'b0, 8'h94);
    one(8'h80, d9, 1'b1, 8'h00);
    one(8'h10, d9, 1'b1, 8'h00);
    wr(rx_pkg::OFS_TSC, 8'h14);
    one(8'h90, d9, 1'b1, 8'h00);
    wr(rx_pkg::OFS_TSC, 8'h04);
    sleep_i <= 1'b1;
    one(8'h90, d9, 1'b1, 8'h00);
    sleep_i <= 1'b0;
    $display("test modes done");
    for (int i = 0; i < 4; i++) begin
      ov[i] = 8'($urandom_range(0, 255));
      u_serial_tx_model.send({1'b0, ov[i]}, 8, 1'b1, bc);
      if (i == 2) rd(rx_pkg::OFS_RSC, 8'h92, 8'hff);
    end
    rd(rx_pkg::OFS_RXBUF, ov[0], 8'hff);
    rd(rx_pkg::OFS_RXBUF, ov[1], 8'hff);
    rd(rx_pkg::OFS_FLAGS, 8'h00, 8'hff);
    wr(rx_pkg::OFS_RSC, 8'h80);
    rd(rx_pkg::OFS_RSC, 8'h80, 8'hff);
    $display("test overrun done");
    for (int s = 0; s < 2; s++) begin
      wr(rx_pkg::OFS_RSC, 8'h90);
      wr(rx_pkg::OFS_BAUD, 8'h02);
      sleep_i <= s[0];
      fork
        u_serial_tx_model.wake_zero(bc);
        begin
          repeat (40) @(posedge clk_i);
          rd(rx_pkg::OFS_FLAGS, 8'h20, 8'hff);
          rd(rx_pkg::OFS_BAUD, 8'h02, 8'hbf);
        end
      join
      sleep_i <= 1'b0;
      rd(rx_pkg::OFS_BAUD, 8'h00, 8'hbf);
      rd(rx_pkg::OFS_RXBUF, 8'h00, 8'h00);
      rd(rx_pkg::OFS_FLAGS, 8'h00, 8'hff);
    end
    $display("test wake done");
    complete_run();
  end
endmodule
